// >>> src/ppsti_defines.svh
// constants for the pulse-per-second, time and sound-velocity input block
`ifndef PPSTI_DEFINES_SVH
`define PPSTI_DEFINES_SVH
`define PPSTI_CLK_HZ        100000000
`define PPSTI_CLK_NS        10
`define PPSTI_MIN_WIDTH_NS  1000
`define PPSTI_MIN_WIDTH_CYC ((`PPSTI_MIN_WIDTH_NS + `PPSTI_CLK_NS - 1) / `PPSTI_CLK_NS)
`define PPSTI_TOL_PPM       100
`define PPSTI_PPM_DIV       1000000
`define PPSTI_PERIOD_CYC    100000000
`define PPSTI_FLASH_CYC     10000000
`define PPSTI_ACTIVE_CYC    200000000
`define PPSTI_BAUD          9600
`define PPSTI_UTC_DIGITS    4'hC
`define PPSTI_ZDA_FIELDS    3'h4
`define PPSTI_SVC_LEN       8'h15
`define PPSTI_SVC_DIGITS    3'h5
`define PPSTI_SVC_SCALE     24'h000064
`define PPSTI_INT_MAX       4'h4
`define PPSTI_FRAC_MAX      2'h3
`define PPSTI_CH_LF         8'h0A
`define PPSTI_CH_CR         8'h0D
`define PPSTI_CH_DOT        8'h2E
`define PPSTI_CH_COMMA      8'h2C
`define PPSTI_CH_ZERO       8'h30
`define PPSTI_CH_NINE       8'h39
`define PPSTI_CH_DOLLAR     8'h24
`define PPSTI_CH_U          8'h55
`define PPSTI_CH_T          8'h54
`define PPSTI_CH_C          8'h43
`define PPSTI_CH_Z          8'h5A
`define PPSTI_CH_D          8'h44
`define PPSTI_CH_A          8'h41
`endif

// >>> src/ppsti_pkg.sv
// types shared by the pulse-per-second, time and sound-velocity input block
package ppsti_pkg;
  typedef struct packed {
    logic [7:0] yy;
    logic [7:0] mo;
    logic [7:0] dd;
    logic [7:0] hh;
    logic [7:0] mi;
    logic [7:0] ss;
  } ppsti_time_t;
  typedef struct packed {
    logic red;
    logic green;
  } ppsti_led_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ppsti_byte_t;
  typedef enum logic [3:0] {
    PPSTI_IDLE = 4'h1,
    PPSTI_UTC  = 4'h2,
    PPSTI_ZDA  = 4'h4,
    PPSTI_SKIP = 4'h8
  } ppsti_line_t;
endpackage : ppsti_pkg

// >>> src/ppsti_top.sv
// pulse-per-second qualifier, time message decoder and sound-velocity parser
// What this block does
// - drop pulses narrower than one microsecond
// - reject pulses off period by 100ppm, red
// - green flash per accepted pulse, one hertz
// - ZDA after pulse describes preceding pulse
// - UTC held, applied at next accepted pulse
// - UTC arriving means ZDA is ignored for ACTIVE_CYC cycles
// - UTC string: prefix, date, space, time
// - UTC status code never affects acceptance
// - serial and network time decode alike
// - only velocity kept from sound sentences
// - 39-char comma sentence, velocity last
// - 49-char variant with pressure, velocity last
// - format found automatically, 21-char fixed record
// - velocity-only sentence, up to four integer digits
// - input indicator green, red or orange
// - standard asynchronous character framing
`timescale 1ns/100ps
`default_nettype none
`include "ppsti_defines.svh"
module ppsti_top #(
  parameter int unsigned BAUD       = `PPSTI_BAUD,
  parameter int unsigned PERIOD_CYC = `PPSTI_PERIOD_CYC,
  parameter int unsigned FLASH_CYC  = `PPSTI_FLASH_CYC,
  parameter int unsigned ACTIVE_CYC = `PPSTI_ACTIVE_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ppsPin,
  input  wire logic                 gpsRxd,
  input  wire logic                 svRxd,
  input  wire ppsti_pkg::ppsti_byte_t netTime,
  input  wire ppsti_pkg::ppsti_byte_t netSv,
  output var  ppsti_pkg::ppsti_led_t  ppsLed,
  output var  ppsti_pkg::ppsti_led_t  gpsLed,
  output var  ppsti_pkg::ppsti_led_t  svLed,
  output var  ppsti_pkg::ppsti_time_t timeBase,
  output logic [31:0]               subSecond,
  output logic                      ppsAccept,
  output logic [23:0]               velocity,
  output logic                      velocityStb
);
  import ppsti_pkg::*;
  localparam int unsigned BAUD_DIV = `PPSTI_CLK_HZ / BAUD;
  localparam int unsigned CW       = $clog2(BAUD_DIV + 1);
  localparam longint      TOL      = longint'(PERIOD_CYC) * `PPSTI_TOL_PPM / `PPSTI_PPM_DIV;
  localparam logic [31:0] PER_LO   = 32'(longint'(PERIOD_CYC) - TOL);
  localparam logic [31:0] PER_HI   = 32'(longint'(PERIOD_CYC) + TOL);
  localparam logic [7:0]  MIN_W    = 8'(`PPSTI_MIN_WIDTH_CYC);

  wire logic [1:0] rxPin = {svRxd, gpsRxd};
  ppsti_byte_t     rxByte [2];
  logic            rxFerr [2];

  // two serial receivers, 8N1, sampled mid-bit
  for (genvar g = 0; g < 2; g++) begin : uart
    logic [1:0]    sync_r;
    logic          busy_r;
    logic [CW-1:0] cnt_r;
    logic [3:0]    bit_r;
    logic [7:0]    sh_r;
    wire logic     rxd = sync_r[1];
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        sync_r <= 2'h3;
        busy_r <= 1'b0;
        cnt_r <= '0;
        bit_r <= 4'h0;
        sh_r <= 8'h00;
        rxByte[g] <= '0;
        rxFerr[g] <= 1'b0;
      end else begin
        sync_r <= {sync_r[0], rxPin[g]};
        rxByte[g].valid <= 1'b0;
        rxFerr[g] <= 1'b0;
        if (!busy_r) begin
          if (!rxd) begin
            busy_r <= 1'b1;
            cnt_r <= CW'(BAUD_DIV / 2);
            bit_r <= 4'h0;
          end
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - 1'b1;
        end else begin
          cnt_r <= CW'(BAUD_DIV - 1);
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'h0 && rxd) begin
            busy_r <= 1'b0; // glitch, not a start bit
          end else if (bit_r == 4'h9) begin
            busy_r <= 1'b0;
            rxByte[g] <= '{valid: rxd, data: sh_r};
            rxFerr[g] <= !rxd;
          end else if (bit_r != 4'h0) begin
            sh_r <= {rxd, sh_r[7:1]};
          end
        end
      end
    end
  end

  // one line at a time per stream; whichever source opens a line owns it until LF or, for a serial line, a framing error
  logic tLock_r, tNet_r, sLock_r, sNet_r;
  wire logic  tUseNet = tLock_r ? tNet_r : !rxByte[0].valid;
  wire logic  sUseNet = sLock_r ? sNet_r : !rxByte[1].valid;
  wire ppsti_byte_t tIn = tUseNet ? netTime : rxByte[0];
  wire ppsti_byte_t sIn = sUseNet ? netSv : rxByte[1];
  wire logic  tAbort = rxFerr[0] && !tUseNet;
  wire logic  sAbort = rxFerr[1] && !sUseNet;
  wire logic  tLf = tIn.valid && tIn.data == `PPSTI_CH_LF;
  wire logic  sLf = sIn.valid && sIn.data == `PPSTI_CH_LF;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tLock_r <= 1'b0;
      tNet_r <= 1'b0;
      sLock_r <= 1'b0;
      sNet_r <= 1'b0;
    end else begin
      tLock_r <= (tIn.valid || tLock_r) && !tLf && !tAbort;
      tNet_r <= tUseNet;
      sLock_r <= (sIn.valid || sLock_r) && !sLf && !sAbort;
      sNet_r <= sUseNet;
    end
  end

  // time line parser
  ppsti_line_t     tKind_r;
  logic [5:0]      tPos_r;
  logic [2:0]      tField_r;
  logic [3:0]      tDig_r;
  logic [5:0][7:0] tWork_r;
  wire logic       tIsDig = tIn.data >= `PPSTI_CH_ZERO && tIn.data <= `PPSTI_CH_NINE;
  wire logic [7:0] tDv = tIn.data - `PPSTI_CH_ZERO;
  // index 5 is year down to 0 for seconds; 7 drops the digit
  wire logic [2:0] utcSel = (tDig_r < `PPSTI_UTC_DIGITS) ? 3'(3'h5 - tDig_r[3:1]) : 3'h7;
  wire logic [2:0] zdaSel = (tField_r == 3'h1) ? ((tDig_r < 4'h6) ? 3'(3'h2 - tDig_r[3:1]) : 3'h7) :
                            (tField_r == 3'h2) ? 3'h3 : (tField_r == 3'h3) ? 3'h4 :
                            (tField_r == 3'h4) ? 3'h5 : 3'h7;
  wire logic [2:0] tSel = (tKind_r == PPSTI_UTC) ? utcSel : zdaSel;
  wire logic [3:0] tChk = (tPos_r == 6'h1) ? 4'(tIn.data == `PPSTI_CH_T) :
                          (tPos_r == 6'h2) ? 4'(tIn.data == `PPSTI_CH_C) : 4'h1;
  wire logic       zChk = (tPos_r == 6'h3) ? tIn.data == `PPSTI_CH_Z :
                          (tPos_r == 6'h4) ? tIn.data == `PPSTI_CH_D :
                          (tPos_r == 6'h5) ? tIn.data == `PPSTI_CH_A : 1'b1;
  // status code letters are neither digits nor counted, so 'ab' never matters
  wire logic       utcDone = tLf && tKind_r == PPSTI_UTC && tDig_r >= `PPSTI_UTC_DIGITS;
  wire logic       zdaDone = tLf && tKind_r == PPSTI_ZDA && tField_r >= `PPSTI_ZDA_FIELDS;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tKind_r <= PPSTI_IDLE;
      tPos_r <= 6'h00;
      tField_r <= 3'h0;
      tDig_r <= 4'h0;
      tWork_r <= '0;
    end else if (tAbort || tLf) begin
      tKind_r <= PPSTI_IDLE;
    end else if (tIn.valid) begin
      tPos_r <= (tPos_r == 6'h3F) ? tPos_r : tPos_r + 6'h01;
      unique case (tKind_r)
        PPSTI_IDLE: begin
          tKind_r <= (tIn.data == `PPSTI_CH_U) ? PPSTI_UTC :
                     (tIn.data == `PPSTI_CH_DOLLAR) ? PPSTI_ZDA : PPSTI_SKIP;
          tPos_r <= 6'h01;
          tField_r <= 3'h0;
          tDig_r <= 4'h0;
        end
        PPSTI_UTC, PPSTI_ZDA: begin
          if ((tKind_r == PPSTI_UTC && tChk == 4'h0) || (tKind_r == PPSTI_ZDA && !zChk)) begin
            tKind_r <= PPSTI_SKIP;
          end else if (tKind_r == PPSTI_ZDA && tIn.data == `PPSTI_CH_COMMA) begin
            tField_r <= (tField_r == 3'h7) ? tField_r : tField_r + 3'h1;
            tDig_r <= 4'h0;
          end else if (tIsDig && tPos_r > 6'h2) begin
            // keep the last two digits, so a four-digit year folds to two
            if (tSel != 3'h7) tWork_r[tSel] <= 8'((tWork_r[tSel] % 8'd10) * 8'd10 + tDv);
            tDig_r <= (tDig_r == 4'hF) ? tDig_r : tDig_r + 4'h1;
          end
        end
        PPSTI_SKIP: ;
      endcase
    end
  end

  // pulse input: synchronise, qualify width, then period
  logic [1:0]  ppsS_r;
  logic [7:0]  hiCnt_r;
  logic [31:0] perCnt_r;
  logic        havePrev_r;
  wire logic   ppsQual = ppsS_r[1] && hiCnt_r == MIN_W - 8'h01;
  wire logic   perOk = havePrev_r && perCnt_r >= PER_LO && perCnt_r <= PER_HI;
  wire logic   ppsGood = ppsQual && perOk;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ppsS_r <= 2'h0;
      hiCnt_r <= 8'h00;
      perCnt_r <= 32'h0000_0000;
      havePrev_r <= 1'b0;
    end else begin
      ppsS_r <= {ppsS_r[0], ppsPin};
      hiCnt_r <= !ppsS_r[1] ? 8'h00 : (hiCnt_r == MIN_W) ? hiCnt_r : hiCnt_r + 8'h01;
      perCnt_r <= ppsQual ? 32'h0000_0000 : (perCnt_r == 32'hFFFF_FFFF) ? perCnt_r : perCnt_r + 32'h1;
      if (ppsQual) havePrev_r <= 1'b1;
    end
  end

  // time base: UTC waits for the next good pulse, ZDA names the pulse just gone
  logic        utcPend_r;
  ppsti_time_t utcHeld_r;
  logic [31:0] utcAge_r;
  wire logic   utcActive = utcAge_r != 32'h0000_0000;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      utcPend_r <= 1'b0;
      utcHeld_r <= '0;
      utcAge_r <= 32'h0000_0000;
      timeBase <= '0;
      subSecond <= 32'h0000_0000;
      ppsAccept <= 1'b0;
    end else begin
      ppsAccept <= ppsGood;
      utcAge_r <= utcDone ? ACTIVE_CYC : utcActive ? utcAge_r - 32'h1 : utcAge_r;
      // the qualifier lags the edge by the minimum width, so start from there
      subSecond <= ppsGood ? 32'(MIN_W) : subSecond + 32'h1;
      if (utcDone) begin
        utcHeld_r <= ppsti_time_t'(tWork_r);
        utcPend_r <= 1'b1;
      end else if (ppsGood) begin
        utcPend_r <= 1'b0;
      end
      if (ppsGood && utcPend_r) begin
        timeBase <= utcHeld_r;
      end else if (zdaDone && !utcActive) begin
        timeBase <= ppsti_time_t'(tWork_r);
      end
    end
  end

  // pulse indicator: green when accepted, red when rejected
  logic [31:0] flash_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flash_r <= 32'h0000_0000;
      ppsLed <= '0;
    end else if (ppsQual) begin
      flash_r <= FLASH_CYC;
      ppsLed <= '{red: !perOk, green: perOk};
    end else if (flash_r != 32'h0000_0000) begin
      flash_r <= flash_r - 32'h1;
    end else begin
      ppsLed <= '0;
    end
  end

  // sound velocity: keep only the last numeric field, or the fixed record's head
  logic [7:0]  sLen_r;
  logic [16:0] sHead_r;
  logic [2:0]  sHeadN_r;
  logic [13:0] sInt_r;
  logic [9:0]  sFrac_r;
  logic [3:0]  sIntN_r;
  logic [1:0]  sFracN_r;
  logic        sInFrac_r, sTok_r, sCand_r;
  logic [23:0] sCandV_r;
  wire logic   sIsDig = sIn.data >= `PPSTI_CH_ZERO && sIn.data <= `PPSTI_CH_NINE;
  wire logic [3:0] sDv = 4'(sIn.data - `PPSTI_CH_ZERO);
  wire logic   sTokEnd = sIn.valid && !sIsDig && sIn.data != `PPSTI_CH_DOT;
  wire logic [9:0] sFracMm = (sFracN_r == 2'h1) ? 10'(sFrac_r * 10'd100) :
                             (sFracN_r == 2'h2) ? 10'(sFrac_r * 10'd10) : sFrac_r;
  wire logic [23:0] sTokV = 24'(sInt_r) * 24'd1000 + 24'(sFracMm);
  wire logic   sTokOk = sTok_r && sIntN_r <= `PPSTI_INT_MAX;
  wire logic   sIsSvc = sLen_r + 8'h01 == `PPSTI_SVC_LEN && sHeadN_r == `PPSTI_SVC_DIGITS;
  wire logic   sDone = sLf && (sIsSvc || sCand_r || sTokOk);
  wire logic [23:0] sVel = sIsSvc ? 24'(sHead_r) * `PPSTI_SVC_SCALE : sTokOk ? sTokV : sCandV_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sLen_r <= 8'h00;
      sHead_r <= 17'h0;
      sHeadN_r <= 3'h0;
      {sInt_r, sFrac_r, sIntN_r, sFracN_r, sInFrac_r, sTok_r, sCand_r} <= '0;
      sCandV_r <= 24'h0;
      velocity <= 24'h0;
      velocityStb <= 1'b0;
    end else begin
      velocityStb <= sDone;
      if (sDone) velocity <= sVel;
      if (sAbort || sLf) begin
        sLen_r <= 8'h00;
        sHeadN_r <= 3'h0;
        sHead_r <= 17'h0;
        {sInt_r, sFrac_r, sIntN_r, sFracN_r, sInFrac_r, sTok_r, sCand_r} <= '0;
      end else if (sIn.valid) begin
        sLen_r <= (sLen_r == 8'hFF) ? sLen_r : sLen_r + 8'h01;
        // full-width position compare, so digits deeper in a line never pose as a record head
        if (sIsDig && 8'(sHeadN_r) == sLen_r && sHeadN_r < `PPSTI_SVC_DIGITS) begin
          sHead_r <= 17'(sHead_r * 17'd10 + 17'(sDv));
          sHeadN_r <= sHeadN_r + 3'h1;
        end
        if (sTokEnd) begin
          // a unit or other text closes a number but never replaces it
          if (sTokOk) begin
            sCandV_r <= sTokV;
            sCand_r <= 1'b1;
          end
          {sInt_r, sFrac_r, sIntN_r, sFracN_r, sInFrac_r, sTok_r} <= '0;
        end else if (sIn.data == `PPSTI_CH_DOT) begin
          sInFrac_r <= 1'b1;
        end else if (sInFrac_r) begin
          if (sFracN_r < `PPSTI_FRAC_MAX) begin
            sFrac_r <= 10'(sFrac_r * 10'd10 + 10'(sDv));
            sFracN_r <= sFracN_r + 2'h1;
          end
          sTok_r <= 1'b1;
        end else begin
          sInt_r <= 14'(sInt_r * 14'd10 + 14'(sDv));
          sIntN_r <= (sIntN_r == 4'hF) ? sIntN_r : sIntN_r + 4'h1;
          sTok_r <= 1'b1;
        end
      end
    end
  end

  // input indicators: recent decode green, bytes only orange, silence red
  wire logic [1:0] actEvt = {sIn.valid || rxFerr[1], tIn.valid || rxFerr[0]};
  wire logic [1:0] okEvt = {sDone, utcDone || zdaDone};
  ppsti_led_t      inLed [2];
  for (genvar g = 0; g < 2; g++) begin : ind
    logic [31:0] act_r, ok_r;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        act_r <= 32'h0000_0000;
        ok_r <= 32'h0000_0000;
        inLed[g] <= '{red: 1'b1, green: 1'b0};
      end else begin
        act_r <= actEvt[g] ? ACTIVE_CYC : (act_r != 32'h0) ? act_r - 32'h1 : act_r;
        ok_r <= okEvt[g] ? ACTIVE_CYC : (ok_r != 32'h0) ? ok_r - 32'h1 : ok_r;
        inLed[g] <= '{red: ok_r == 32'h0, green: ok_r != 32'h0 || act_r != 32'h0};
      end
    end
  end
  assign gpsLed = inLed[0];
  assign svLed = inLed[1];
endmodule : ppsti_top
`default_nettype wire

// >>> tb/ppsti_top_checker.sv
// port assertions for the pulse, time and velocity input block
`timescale 1ns/100ps
`default_nettype none
module ppsti_top_checker #(
  parameter int unsigned BAUD       = 9600,
  parameter int unsigned PERIOD_CYC = 100000000,
  parameter int unsigned FLASH_CYC  = 10000000,
  parameter int unsigned ACTIVE_CYC = 200000000
) (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   ppsPin,
  input wire logic                   gpsRxd,
  input wire logic                   svRxd,
  input wire ppsti_pkg::ppsti_byte_t netTime,
  input wire ppsti_pkg::ppsti_byte_t netSv,
  input wire ppsti_pkg::ppsti_led_t  ppsLed,
  input wire ppsti_pkg::ppsti_led_t  gpsLed,
  input wire ppsti_pkg::ppsti_led_t  svLed,
  input wire ppsti_pkg::ppsti_time_t timeBase,
  input wire logic [31:0]            subSecond,
  input wire logic                   ppsAccept,
  input wire logic [23:0]            velocity,
  input wire logic                   velocityStb
);
  import ppsti_pkg::*;
  // one serial character plus a bit of slack, in clock cycles
  localparam int unsigned CHAR_CYC = 11 * (100000000 / BAUD);
  logic [7:0]  hiRun;
  logic [31:0] ledOn;
  logic [31:0] rxdIdle;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // run lengths of the raw pins and the lit lamp; the pin counts saturate so long highs never wrap, the lamp count does not
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hiRun <= 8'h00;
      ledOn <= 32'h0;
      rxdIdle <= 32'hFFFF_FFFF;
    end else begin
      rxdIdle <= !gpsRxd ? 32'h0 : ((rxdIdle == 32'hFFFF_FFFF) ? rxdIdle : rxdIdle + 32'h1);
      hiRun <= !ppsPin ? 8'h00 : ((hiRun == 8'hFF) ? hiRun : hiRun + 8'h01);
      ledOn <= (ppsLed == 2'h0) ? 32'h0 : ledOn + 32'h1;
    end
  end
  a_pulse_width: assert property (ppsAccept |-> $past(hiRun, 2) >= 8'h5F)
    else $error("accepted pulse was too narrow");
  a_accept_green: assert property (ppsAccept |-> ##[0:1] (ppsLed.green && !ppsLed.red))
    else $error("accepted pulse not shown green");
  a_reject_red: assert property ($rose(ppsLed.red) |-> !ppsAccept)
    else $error("red flash together with accept");
  a_lamp_excl: assert property (!(ppsLed.red && ppsLed.green))
    else $error("pulse lamp red and green at once");
  a_flash_len: assert property (ledOn <= FLASH_CYC + 1)
    else $error("pulse lamp lit too long");
  a_sub_restart: assert property (ppsAccept |-> subSecond == 32'h64)
    else $error("sub-second not restarted on accept");
  // the first edge after release still sees a reset-time sample, so skip it
  a_sub_count: assert property (!ppsAccept && !$past(rst) |-> subSecond == $past(subSecond) + 32'h1)
    else $error("sub-second did not count");
  a_vel_pulse: assert property (velocityStb |=> !velocityStb)
    else $error("velocity strobe longer than a cycle");
  a_vel_change: assert property ($changed(velocity) |-> velocityStb)
    else $error("velocity changed without strobe");
  a_time_cause: assert property ($changed(timeBase) |->
                                 ppsAccept || $past(netTime.valid) || $past(rxdIdle) <= CHAR_CYC)
    else $error("time base changed without cause");
  c_accept: cover property (ppsAccept);
  c_reject: cover property ($rose(ppsLed.red));
  c_velocity: cover property (velocityStb);
  c_zda_load: cover property ($changed(timeBase) && !ppsAccept);
endmodule : ppsti_top_checker
`default_nettype wire

// >>> tb/ppsti_serial_src.sv
// serial source standing in for the time receiver and the velocity probe
`timescale 1ns/100ps
`default_nettype none
module ppsti_serial_src #(
  parameter int BIT_CYC = 20
) (
  input  wire logic mclk,
  output var  logic txd
);
  initial txd = 1'b1;
  // start low, eight bits lsb first, stop high; line rests high between characters
  task automatic send(input string s);
    logic [9:0] frame;
    for (int i = 0; i < s.len(); i++) begin
      frame = {1'b1, s[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        @(posedge mclk);
        txd <= frame[b];
        repeat (BIT_CYC - 1) @(posedge mclk);
      end
    end
  endtask : send
endmodule : ppsti_serial_src
`default_nettype wire

// >>> tb/tb_ppsti_top.sv
// self-checking bench for the pulse, time and velocity input block
`timescale 1ns/100ps
`default_nettype none
module tb_ppsti_top;
  import ppsti_pkg::*;
  localparam int BAUD_T = 5000000;
  localparam int LIMIT  = 90000;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ppsPin = 1'b0;
  wire         gpsRxd;
  wire         svRxd;
  ppsti_byte_t netTime = '0;
  ppsti_byte_t netSv = '0;
  ppsti_led_t  ppsLed, gpsLed, svLed;
  ppsti_time_t timeBase, tbAt, utc1, utc2, utc3, zda1, zda2;
  logic [31:0] subSecond, subAt, seed = 32'hCCB09B01;
  logic [23:0] velocity;
  logic        ppsAccept, velocityStb, acc, sawRed, sawGreen;
  int          mismatches = 0, total_checks = 0, cyc = 0, vi, vf;
  string       s;
  string       vs [4] = '{"1500.5\r\n", "012.3456,01.23456,0035.1234, 1493.456\r\n",
                          "012.3456,01.23456,00010.500,0035.1234, 1494.321\r\n", "1492100012015003000\r\n"};
  logic [23:0] ve [4] = '{24'h16E554, 24'h16C9D0, 24'h16CD31, 24'h16C484};
  ppsti_top #(.BAUD(BAUD_T), .PERIOD_CYC(20000), .FLASH_CYC(50), .ACTIVE_CYC(5000)) u_ppsti_top (
    .mclk(mclk), .rst(rst), .ppsPin(ppsPin), .gpsRxd(gpsRxd), .svRxd(svRxd), .netTime(netTime), .netSv(netSv),
    .ppsLed(ppsLed), .gpsLed(gpsLed), .svLed(svLed), .timeBase(timeBase), .subSecond(subSecond),
    .ppsAccept(ppsAccept), .velocity(velocity), .velocityStb(velocityStb));
  ppsti_serial_src #(.BIT_CYC(100000000 / BAUD_T)) u_ppsti_serial_src_gps (.mclk(mclk), .txd(gpsRxd));
  ppsti_serial_src #(.BIT_CYC(100000000 / BAUD_T)) u_ppsti_serial_src_sv (.mclk(mclk), .txd(svRxd));
  always #5 mclk = ~mclk;
  // cycle count; also cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] r);
    return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction : lfsr
  function automatic ppsti_time_t mkTime(input logic [7:0] mi, input logic [31:0] r);
    return {8'h11, 8'h04, 8'h0D, 8'h0C, mi, 8'(r % 60)};
  endfunction : mkTime
  function automatic string utcStr(input ppsti_time_t t, input logic [15:0] code);
    return $sformatf("UTC %02d.%02d.%02d %02d:%02d:%02d %s\r\n", t.yy, t.mo, t.dd, t.hh, t.mi, t.ss, code);
  endfunction : utcStr
  function automatic string zdaStr(input ppsti_time_t t);
    return $sformatf("$GPZDA,%02d%02d%02d.00,%02d,%02d,20%02d,00,00*6A\r\n", t.hh, t.mi, t.ss, t.dd, t.mo, t.yy);
  endfunction : zdaStr
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // network bytes back to back, one valid cycle each
  task automatic netSend(input string str, input bit toSv);
    for (int i = 0; i < str.len(); i++) begin
      @(posedge mclk);
      if (toSv) netSv <= {1'b1, str[i]};
      else netTime <= {1'b1, str[i]};
    end
    @(posedge mclk);
    netSv <= '0;
    netTime <= '0;
  endtask : netSend
  task automatic velWait(input logic [23:0] exp, input int n);
    logic found;
    logic [23:0] got;
    found = 0;
    got = '0;
    repeat (n) begin
      @(negedge mclk);
      if (velocityStb === 1'b1 && !found) begin
        found = 1;
        got = velocity;
      end
    end
    check(found, 1);
    check(got, exp);
  endtask : velWait
  // pulse rising at a given cycle; watches accept and lamp for 200 cycles
  task automatic ppsPulse(input int at, input int w, input bit expAcc, input bit expRed);
    acc = 0;
    sawRed = 0;
    sawGreen = 0;
    @(posedge mclk);
    while (cyc < at) @(posedge mclk);
    ppsPin <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk);
      if (i == w) ppsPin <= 1'b0;
      @(negedge mclk);
      if (ppsAccept === 1'b1) begin
        acc = 1;
        tbAt = timeBase;
        subAt = subSecond;
      end
      sawRed |= ppsLed.red === 1'b1;
      sawGreen |= ppsLed.green === 1'b1;
    end
    check(acc, expAcc);
    check(sawRed, expRed);
    check(sawGreen, expAcc);
  endtask : ppsPulse
  initial begin
    repeat (9) @(posedge mclk);
    @(negedge mclk);
    check(gpsLed, 2'h2);
    check(svLed, 2'h2);
    check(ppsLed, 2'h0);
    check(timeBase, 48'h0);
    check(velocity, 48'h0);
    @(posedge mclk);
    rst <= 1'b0;
    ppsPulse(100, 150, 0, 1);
    ppsPulse(5000, 50, 0, 0);
    seed = lfsr(seed);
    utc1 = mkTime(8'h22, seed);
    u_ppsti_serial_src_gps.send(utcStr(utc1, {8'h41 + 8'(seed[4:0] % 26), 8'h5A}));
    repeat (10) @(negedge mclk);
    check(gpsLed, 2'h1);
    for (int k = 0; k < 4; k++) begin
      netSend(vs[k], 1);
      velWait(ve[k], 20);
    end
    check(svLed, 2'h1);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      vi = 1400 + int'(seed[15:0] % 200);
      vf = int'(seed[31:16] % 1000);
      if (k[0]) begin
        s = $sformatf(" %0d.%03d m/sec\r\n", vi, vf);
        fork
          u_ppsti_serial_src_sv.send(s);
          velWait(24'(vi * 1000 + vf), s.len() * 200 + 50);
        join
      end else begin
        netSend($sformatf("%0d.%03d\r\n", vi, vf), 1);
        velWait(24'(vi * 1000 + vf), 20);
      end
    end
    ppsPulse(20100, 150, 1, 0);
    check(tbAt, utc1);
    check(subAt, 32'h64);
    utc2 = mkTime(8'h23, lfsr(seed));
    u_ppsti_serial_src_gps.send(utcStr(utc2, 16'h6162));
    zda1 = mkTime(8'h24, seed);
    netSend(zdaStr(zda1), 0);
    repeat (4) @(negedge mclk);
    check(timeBase, utc1);
    while (cyc < 32000) @(posedge mclk);
    zda2 = mkTime(8'h25, seed);
    netSend(zdaStr(zda2), 0);
    repeat (2) @(negedge mclk);
    check(timeBase, zda2);
    ppsPulse(40110, 150, 0, 1);
    check(timeBase, zda2);
    utc3 = mkTime(8'h26, seed);
    netSend(utcStr(utc3, 16'h7879), 0);
    ppsPulse(60110, 150, 1, 0);
    check(tbAt, utc3);
    conclude();
  end
endmodule : tb_ppsti_top
bind ppsti_top ppsti_top_checker #(.BAUD(BAUD), .PERIOD_CYC(PERIOD_CYC), .FLASH_CYC(FLASH_CYC),
  .ACTIVE_CYC(ACTIVE_CYC)) u_ppsti_top_checker (.mclk(mclk), .rst(rst), .ppsPin(ppsPin), .gpsRxd(gpsRxd),
  .svRxd(svRxd), .netTime(netTime), .netSv(netSv), .ppsLed(ppsLed), .gpsLed(gpsLed), .svLed(svLed),
  .timeBase(timeBase), .subSecond(subSecond), .ppsAccept(ppsAccept), .velocity(velocity), .velocityStb(velocityStb));
`default_nettype wire
